// >>> logic/ssp_ctrl.sv
`timescale 1ns/10ps
// serial programming, latches, power control, dividers, detector and monitor

module ssp_ctrl
    import ssp_pkg::*;
#(
    parameter bit LOW_BAND_VARIANT = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic serial_clk,
    input  wire logic serial_data,
    input  wire logic latch_load_strobe,
    input  wire logic chip_enable,
    input  wire logic osc_in,
    input  wire logic rf_in,
    output logic      pump_up,
    output logic      pump_down,
    output logic      pump_output_oe,
    output logic      divider_lock_monitor_out,
    output logic      powered_up
);

    localparam int MOD_BASE = LOW_BAND_VARIANT ? PRESC_LOW_MOD : PRESC_HIGH_MOD;

    // one-hot latch select from the control bits
    function automatic logic [2:0] latch_select(input logic [CTL_W-1:0] ctl);
        logic [2:0] sel;
        sel = 3'h0;
        unique case (ctl)
            CTL_REF:  sel = 3'h1;
            CTL_DIV:  sel = 3'h2;
            CTL_FUNC: sel = 3'h4;
            default:  sel = 3'h0;
        endcase
        return sel;
    endfunction

    // ---- link domain: serial shift register ----
    logic [SHIFT_LEN-1:0] shift_reg;

    always_ff @(posedge serial_clk or posedge reset) begin
        if (reset) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= {shift_reg[SHIFT_LEN-2:0], serial_data};
        end
    end

    // ---- system domain: pin synchronisers ----
    logic [1:0] strobe_sync_reg;
    logic       strobe_prev_reg;
    logic [1:0] ce_sync_reg;
    logic [1:0] osc_sync_reg;
    logic       osc_prev_reg;
    logic [1:0] rf_sync_reg;
    logic       rf_prev_reg;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            strobe_sync_reg <= 2'h0;
            strobe_prev_reg <= 1'b0;
        end else begin
            strobe_sync_reg <= {strobe_sync_reg[0], latch_load_strobe};
            strobe_prev_reg <= strobe_sync_reg[1];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ce_sync_reg <= 2'h0;
        end else begin
            ce_sync_reg <= {ce_sync_reg[0], chip_enable};
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            osc_sync_reg <= 2'h0;
            osc_prev_reg <= 1'b0;
            rf_sync_reg  <= 2'h0;
            rf_prev_reg  <= 1'b0;
        end else begin
            osc_sync_reg <= {osc_sync_reg[0], osc_in};
            osc_prev_reg <= osc_sync_reg[1];
            rf_sync_reg  <= {rf_sync_reg[0], rf_in};
            rf_prev_reg  <= rf_sync_reg[1];
        end
    end

    logic strobe_rise;
    logic osc_edge;
    logic rf_edge;

    assign strobe_rise = strobe_sync_reg[1] && !strobe_prev_reg;
    assign osc_edge    = osc_sync_reg[1] && !osc_prev_reg;
    assign rf_edge     = rf_sync_reg[1] && !rf_prev_reg;

    // ---- latches ----
    logic [SHIFT_LEN-1:0] ref_latch_reg;
    logic [SHIFT_LEN-1:0] div_latch_reg;
    logic [SHIFT_LEN-1:0] func_latch_reg;
    logic [2:0]           load_sel;

    // shift word is not gated by the strobe; it holds only while serial_clk is idle, so it is taken here
    assign load_sel = strobe_rise ? latch_select(shift_reg[CTL_W-1:0]) : 3'h0;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ref_latch_reg <= REF_LATCH_RST;
        end else if (load_sel[0]) begin
            ref_latch_reg <= shift_reg;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            div_latch_reg <= DIV_LATCH_RST;
        end else if (load_sel[1]) begin
            div_latch_reg <= shift_reg;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            func_latch_reg <= FUNC_LATCH_RST;
        end else if (load_sel[2]) begin
            func_latch_reg <= shift_reg;
        end
    end

    logic [REF_W-1:0]  ref_count;
    logic [SWAL_W-1:0] swallow_count;
    logic [MAIN_W-1:0] main_count;
    logic              pd_config;
    logic              pump_float_config;
    ssp_mon_t          mon_sel;

    assign ref_count         = ref_latch_reg[REF_LSB +: REF_W];
    assign swallow_count     = div_latch_reg[SWAL_LSB +: SWAL_W];
    assign main_count        = div_latch_reg[MAIN_LSB +: MAIN_W];
    assign pd_config         = func_latch_reg[PD_BIT];
    assign pump_float_config = func_latch_reg[TRI_BIT];
    assign mon_sel           = ssp_mon_t'(func_latch_reg[MUX_LSB +: MUX_W]);

    // ---- power control ----
    logic powered_reg;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            powered_reg <= 1'b0;
        end else if (!ce_sync_reg[1]) begin
            powered_reg <= 1'b0;
        end else begin
            powered_reg <= !pd_config;
        end
    end

    assign powered_up = powered_reg;

    // ---- reference divider ----
    logic [REF_W-1:0] ref_cnt_reg;
    logic             ref_pulse_reg;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ref_cnt_reg   <= '0;
            ref_pulse_reg <= 1'b0;
        end else if (!powered_reg) begin
            ref_cnt_reg   <= '0;
            ref_pulse_reg <= 1'b0;
        end else begin
            ref_pulse_reg <= 1'b0;
            if (osc_edge) begin
                if (REF_W'(ref_cnt_reg + 1'b1) >= ref_count) begin
                    ref_cnt_reg   <= '0;
                    ref_pulse_reg <= 1'b1;
                end else begin
                    ref_cnt_reg <= REF_W'(ref_cnt_reg + 1'b1);
                end
            end
        end
    end

    // ---- feedback divider ----
    logic fb_pulse;

    ssp_fb_divider #(
        .MOD_BASE (MOD_BASE)
    ) u_fb_divider (
        .clk_sys       (clk_sys),
        .reset         (reset),
        .run           (powered_reg),
        .rf_edge       (rf_edge),
        .swallow_count (swallow_count),
        .main_count    (main_count),
        .fb_pulse      (fb_pulse)
    );

    // ---- phase detector ----
    logic up_reg;
    logic dn_reg;
    logic up_next;
    logic dn_next;

    always_comb begin
        up_next = up_reg || ref_pulse_reg;
        dn_next = dn_reg || fb_pulse;
        if (up_next && dn_next) begin
            up_next = 1'b0;
            dn_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
        end else if (!powered_reg) begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
        end else begin
            up_reg <= up_next;
            dn_reg <= dn_next;
        end
    end

    // pump floats in power-down or when programmed to float
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pump_up        <= 1'b0;
            pump_down      <= 1'b0;
            pump_output_oe <= 1'b0;
        end else begin
            pump_up        <= up_reg && powered_reg;
            pump_down      <= dn_reg && powered_reg;
            pump_output_oe <= powered_reg && ce_sync_reg[1] && !pump_float_config;
        end
    end

    // ---- lock detect ----
    logic [ERR_CNT_W-1:0] err_cnt_reg;
    logic [HIT_CNT_W-1:0] hit_cnt_reg;
    logic                 lock_reg;
    logic                 pfd_active;
    logic                 pfd_close;

    assign pfd_active = up_reg || dn_reg;
    assign pfd_close  = (pfd_active || ref_pulse_reg || fb_pulse) && !(up_next || dn_next);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            err_cnt_reg <= '0;
        end else if (!pfd_active) begin
            err_cnt_reg <= '0;
        end else if (err_cnt_reg != '1) begin
            err_cnt_reg <= ERR_CNT_W'(err_cnt_reg + 1'b1);
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hit_cnt_reg <= '0;
            lock_reg    <= 1'b0;
        end else if (!powered_reg) begin
            hit_cnt_reg <= '0;
            lock_reg    <= 1'b0;
        end else if (pfd_close) begin
            if (err_cnt_reg < ERR_CNT_W'(LOCK_WIN_CYC)) begin
                if (hit_cnt_reg == HIT_CNT_W'(LOCK_HITS)) begin
                    lock_reg <= 1'b1;
                end else begin
                    hit_cnt_reg <= HIT_CNT_W'(hit_cnt_reg + 1'b1);
                end
            end else begin
                hit_cnt_reg <= '0;
                lock_reg    <= 1'b0;
            end
        end
    end

    // ---- monitor output ----
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            divider_lock_monitor_out <= 1'b0;
        end else begin
            unique case (mon_sel)
                MON_LOW:  divider_lock_monitor_out <= 1'b0;
                MON_LOCK: divider_lock_monitor_out <= lock_reg;
                MON_REF:  divider_lock_monitor_out <= ref_pulse_reg;
                MON_FB:   divider_lock_monitor_out <= fb_pulse;
            endcase
        end
    end

endmodule

// >>> common/ssp_pkg.sv
// shared constants and types for the serial programming and control front end
package ssp_pkg;

    // serial word layout
    localparam int SHIFT_LEN = 21;
    localparam int CTL_W     = 2;
    localparam logic [1:0] CTL_REF  = 2'h0;
    localparam logic [1:0] CTL_DIV  = 2'h1;
    localparam logic [1:0] CTL_FUNC = 2'h2;

    // reference latch fields
    localparam int REF_LSB = 2;
    localparam int REF_W   = 14;

    // feedback divider latch fields
    localparam int SWAL_LSB = 2;
    localparam int SWAL_W   = 5;
    localparam int MAIN_LSB = 7;
    localparam int MAIN_W   = 13;

    // function latch fields
    localparam int PD_BIT   = 2;
    localparam int MUX_LSB  = 3;
    localparam int MUX_W    = 2;
    localparam int TRI_BIT  = 5;

    // latch values after reset
    localparam logic [SHIFT_LEN-1:0] REF_LATCH_RST  = 21'h000000;
    localparam logic [SHIFT_LEN-1:0] DIV_LATCH_RST  = 21'h000000;
    localparam logic [SHIFT_LEN-1:0] FUNC_LATCH_RST = 21'h000000;

    // dual modulus prescaler base ratios
    localparam int PRESC_LOW_MOD  = 8;
    localparam int PRESC_HIGH_MOD = 32;
    localparam int PRESC_CNT_W    = 6;

    // lock detect: max phase error width and hits in a row
    localparam int LOCK_WIN_NS  = 100;
    localparam int CLK_SYS_NS   = 25;
    localparam int LOCK_WIN_CYC = LOCK_WIN_NS / CLK_SYS_NS;
    localparam int LOCK_HITS    = 3;
    localparam int ERR_CNT_W    = 8;
    localparam int HIT_CNT_W    = 2;

    // monitor output selection
    typedef enum logic [1:0] {
        MON_LOW  = 2'b00,
        MON_LOCK = 2'b01,
        MON_REF  = 2'b10,
        MON_FB   = 2'b11
    } ssp_mon_t;

endpackage

// >>> logic/ssp_fb_divider.sv
`timescale 1ns/10ps
// feedback divider: dual modulus prescaler with swallow and main counters
module ssp_fb_divider
    import ssp_pkg::*;
#(
    parameter int MOD_BASE = PRESC_HIGH_MOD
) (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              run,
    input  wire logic              rf_edge,
    input  wire logic [SWAL_W-1:0] swallow_count,
    input  wire logic [MAIN_W-1:0] main_count,
    output logic                   fb_pulse
);

    localparam logic [PRESC_CNT_W-1:0] MOD_LO = PRESC_CNT_W'(MOD_BASE - 1);
    localparam logic [PRESC_CNT_W-1:0] MOD_HI = PRESC_CNT_W'(MOD_BASE);

    logic [PRESC_CNT_W-1:0] presc_cnt_reg;
    logic [SWAL_W-1:0]      swal_left_reg;
    logic [MAIN_W-1:0]      main_cnt_reg;
    logic [PRESC_CNT_W-1:0] presc_limit;
    logic                   presc_wrap;
    logic                   main_done;

    // divide by base+1 while swallow remains, else by base
    assign presc_limit = (swal_left_reg != '0) ? MOD_HI : MOD_LO;
    assign presc_wrap  = rf_edge && (presc_cnt_reg == presc_limit);
    assign main_done   = (MAIN_W'(main_cnt_reg + 1'b1) >= main_count);

    // prescaler
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            presc_cnt_reg <= '0;
        end else if (!run) begin
            presc_cnt_reg <= '0;
        end else if (presc_wrap) begin
            presc_cnt_reg <= '0;
        end else if (rf_edge) begin
            presc_cnt_reg <= PRESC_CNT_W'(presc_cnt_reg + 1'b1);
        end
    end

    // swallow and main counters
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            swal_left_reg <= '0;
            main_cnt_reg  <= '0;
            fb_pulse      <= 1'b0;
        end else if (!run) begin
            swal_left_reg <= swallow_count;
            main_cnt_reg  <= '0;
            fb_pulse      <= 1'b0;
        end else begin
            fb_pulse <= 1'b0;
            if (presc_wrap) begin
                if (main_done) begin
                    main_cnt_reg  <= '0;
                    swal_left_reg <= swallow_count;
                    fb_pulse      <= 1'b1;
                end else begin
                    main_cnt_reg <= MAIN_W'(main_cnt_reg + 1'b1);
                    if (swal_left_reg != '0) begin
                        swal_left_reg <= SWAL_W'(swal_left_reg - 1'b1);
                    end
                end
            end
        end
    end

endmodule

// >>> testbench/ssp_chk.sv
`timescale 1ns/10ps
// port-level checker for the serial programming front end
module ssp_chk
    import ssp_pkg::*;
#(
    parameter bit LOW_BAND_VARIANT = 1'b0
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic latch_load_strobe,
    input wire logic chip_enable,
    input wire logic osc_in,
    input wire logic rf_in,
    input wire logic pump_up,
    input wire logic pump_down,
    input wire logic pump_output_oe,
    input wire logic divider_lock_monitor_out,
    input wire logic powered_up
);
    logic [SHIFT_LEN-1:0] shadow_reg;
    logic                 le_d_reg;
    logic                 pd_reg;
    logic [1:0]           sel_reg;
    // shadow copy of the serial word
    always_ff @(posedge serial_clk or posedge reset) begin
        if (reset) shadow_reg <= '0;
        else shadow_reg <= {shadow_reg[SHIFT_LEN-2:0], serial_data};
    end
    // shadow copy of the function latch
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            le_d_reg <= 1'b0;
            pd_reg <= 1'b0;
            sel_reg <= 2'h0;
        end else begin
            le_d_reg <= latch_load_strobe;
            if (latch_load_strobe && !le_d_reg && shadow_reg[1:0] == CTL_FUNC) begin
                pd_reg <= shadow_reg[PD_BIT];
                sel_reg <= shadow_reg[MUX_LSB+:MUX_W];
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_ce_low;
        !chip_enable [*4] |=> !powered_up && !pump_output_oe;
    endproperty
    property p_ce_fall;
        $fell(chip_enable) |-> ##[1:4] !pump_output_oe;
    endproperty
    property p_pump_idle;
        !powered_up [*4] |-> !pump_up && !pump_down;
    endproperty
    property p_pd_hold;
        pd_reg [*6] |-> !powered_up;
    endproperty
    property p_pwr_on;
        (chip_enable && !pd_reg) [*6] |-> powered_up;
    endproperty
    property p_pwr_cause;
        powered_up |-> $past(chip_enable, 3);
    endproperty
    property p_mon_low;
        (sel_reg == MON_LOW) [*6] |-> !divider_lock_monitor_out;
    endproperty
    property p_mon_pulse;
        (sel_reg == MON_REF || sel_reg == MON_FB) [*6] ##0 divider_lock_monitor_out
            |=> !divider_lock_monitor_out;
    endproperty
    a_ce_low: assert property (p_ce_low) else $error("output on while chip enable low");
    a_ce_fall: assert property (p_ce_fall) else $error("pump not floated");
    a_pump_idle: assert property (p_pump_idle) else $error("pump active when down");
    a_pd_hold: assert property (p_pd_hold) else $error("up despite power-down bit");
    a_pwr_on: assert property (p_pwr_on) else $error("not powered up");
    a_pwr_cause: assert property (p_pwr_cause) else $error("up without chip enable");
    a_mon_low: assert property (p_mon_low) else $error("monitor not low");
    a_mon_pulse: assert property (p_mon_pulse) else $error("divider pulse too long");
    c_up: cover property ($rose(powered_up));
    c_lock: cover property (sel_reg == MON_LOCK && divider_lock_monitor_out);
    c_pd: cover property (pd_reg && chip_enable);
endmodule

bind ssp_ctrl ssp_chk #(.LOW_BAND_VARIANT(LOW_BAND_VARIANT)) ssp_chk_i (
    .clk_sys(clk_sys), .reset(reset), .serial_clk(serial_clk), .serial_data(serial_data),
    .latch_load_strobe(latch_load_strobe), .chip_enable(chip_enable), .osc_in(osc_in),
    .rf_in(rf_in), .pump_up(pump_up), .pump_down(pump_down), .pump_output_oe(pump_output_oe),
    .divider_lock_monitor_out(divider_lock_monitor_out), .powered_up(powered_up)
);

// >>> testbench/ssp_host_model.sv
`timescale 1ns/10ps
// host side model driving the serial link and load strobe
module ssp_host_model
    import ssp_pkg::*;
(
    output logic serial_clk,
    output logic serial_data,
    output logic latch_load_strobe
);
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        latch_load_strobe = 1'b0;
    end
    // link clock 64 ns, only inside a word
    task automatic send_word(input logic [SHIFT_LEN-1:0] w);
        #7;
        for (int i = SHIFT_LEN - 1; i >= 0; i--) begin
            serial_data = w[i];
            #16 serial_clk = 1'b1;
            #32 serial_clk = 1'b0;
            #16;
        end
        serial_data = ~w[0];
        #100 latch_load_strobe = 1'b1;
        #150 latch_load_strobe = 1'b0;
        #100;
    endtask
endmodule

// >>> testbench/tb.sv
`timescale 1ns/10ps
// top bench: both prescaler variants behind one host model
module tb;
    import ssp_pkg::*;
    logic       clk_sys = 1'b0;
    logic       reset = 1'b1;
    logic       chip_enable = 1'b0;
    logic       stim = 1'b0;
    logic       serial_clk;
    logic       serial_data;
    logic       latch_load_strobe;
    logic [1:0] mon;
    logic [1:0] pwr;
    logic [1:0] oe;
    logic [1:0] pu;
    logic [1:0] pdn;
    logic [31:0] n;
    int         error_cnt = 0;
    int         tests_run = 0;
    int         edge_cnt = 0;
    int         cyc = 0;
    int         div_cnt = 0;
    always #12.5 clk_sys = ~clk_sys;
    // osc and rf share one 200 ns source
    always @(negedge clk_sys) begin
        div_cnt <= (div_cnt == 3) ? 0 : div_cnt + 1;
        if (div_cnt == 3) stim <= ~stim;
    end
    always @(posedge stim) edge_cnt++;
    ssp_host_model ssp_host_model_i (.serial_clk(serial_clk), .serial_data(serial_data),
        .latch_load_strobe(latch_load_strobe));
    for (genvar v = 0; v < 2; v++) begin : g_var
        ssp_ctrl #(.LOW_BAND_VARIANT(v == 1)) ssp_ctrl_i (.clk_sys(clk_sys), .reset(reset),
            .serial_clk(serial_clk), .serial_data(serial_data),
            .latch_load_strobe(latch_load_strobe), .chip_enable(chip_enable), .osc_in(stim),
            .rf_in(stim), .pump_up(pu[v]), .pump_down(pdn[v]), .pump_output_oe(oe[v]),
            .divider_lock_monitor_out(mon[v]), .powered_up(pwr[v]));
    end
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic fn(input logic [1:0] sel, input logic pd, input logic [1:0] ctl);
        ssp_host_model_i.send_word((21'(sel) << MUX_LSB) | (21'(pd) << PD_BIT) | 21'(ctl));
        wait_cyc(8);
    endtask
    // monitor pulse spacing in source edges
    task automatic meas(input int v, output logic [31:0] cnt);
        int k;
        int e0;
        k = 0;
        while (mon[v] !== 1'b1 && k < 3000) begin
            @(negedge clk_sys);
            k++;
        end
        @(negedge clk_sys);
        e0 = edge_cnt;
        while (mon[v] !== 1'b1 && k < 3000) begin
            @(negedge clk_sys);
            k++;
        end
        cnt = edge_cnt - e0;
    endtask
    task automatic t_power();
        fn(MON_LOW, 1'b0, CTL_FUNC);
        chk(pwr[0], 1'b0);
        chk(oe[0], 1'b0);
        chip_enable = 1'b1;
        wait_cyc(8);
        chk(pwr, 2'h3);
        chk(oe[0], 1'b1);
        fn(MON_LOW, 1'b1, CTL_FUNC);
        chk(pwr, 2'h0);
        fn(MON_LOW, 1'b0, CTL_FUNC);
        chk(pwr[0], 1'b1);
        fn(MON_LOW, 1'b1, 2'h3);
        chk(pwr[0], 1'b1);
    endtask
    task automatic t_ref();
        ssp_host_model_i.send_word((21'(3) << REF_LSB) | 21'(CTL_REF));
        fn(MON_REF, 1'b0, CTL_FUNC);
        meas(0, n);
        chk(n, 32'h3);
    endtask
    task automatic t_fb();
        ssp_host_model_i.send_word((21'(2) << MAIN_LSB) | (21'(1) << SWAL_LSB) | 21'(CTL_DIV));
        fn(MON_FB, 1'b0, CTL_FUNC);
        meas(0, n);
        chk(n, 32'(PRESC_HIGH_MOD * 2 + 1));
        meas(1, n);
        chk(n, 32'(PRESC_LOW_MOD * 2 + 1));
        wait_cyc(40);
        chk({pu[1], pdn[1]}, 2'h2);
    endtask
    task automatic t_lock();
        chip_enable = 1'b0;
        ssp_host_model_i.send_word((21'(PRESC_HIGH_MOD * 2 + 1) << REF_LSB) | 21'(CTL_REF));
        fn(MON_LOCK, 1'b0, CTL_FUNC);
        chip_enable = 1'b1;
        wait_cyc(3000);
        chk(mon[0], 1'b1);
        chip_enable = 1'b0;
        wait_cyc(8);
        chk(oe[0], 1'b0);
        chk({pu, pdn}, 4'h0);
    endtask
    initial begin
        wait_cyc(4);
        reset = 1'b0;
        wait_cyc(3);
        t_power();
        t_ref();
        t_fb();
        t_lock();
        wrap_up();
    end
endmodule
